/* common/ext_bus_cfg.svh */
// Offsets, field positions and reset values of the sequencer.
// Assumes inclusion by bare name from files that need these figures.
`ifndef EXT_BUS_CFG_SVH
`define EXT_BUS_CFG_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define OFF_CTRL 8'h00
`define OFF_ADDR 8'h04
`define OFF_WDATA 8'h08
`define OFF_CMD 8'h0C
`define OFF_STATUS 8'h10
`define OFF_RDATA 8'h14
`define OFF_TIM0 8'h20
`define OFF_TIM3 8'h2C

// ****************************************
// Field positions
// ****************************************
`define CTRL_RDY_POL_BIT 0
`define CMD_CS_LSB 0
`define CMD_WRITE_BIT 2
`define CMD_UBE_BIT 3
`define STAT_BUSY_BIT 0
`define STAT_DONE_BIT 1
`define TIM_AS2_BIT 0
`define TIM_WIN_LSB 1
`define TIM_CMD_LSB 3
`define TIM_DSET_BIT 5
`define TIM_ACC_LSB 6
`define TIM_HOLD_LSB 11
`define TIM_RDY_EN_BIT 13
`define TIM_RDY_ASYNC_BIT 14
`define TIM_MUX_BIT 15

// ****************************************
// Reset values
// ****************************************
`define RST_CTRL 1'h0
`define RST_TIM 16'h0000

`endif

/* common/ext_bus_pkg.sv */
// Types shared by the external bus sequencer.
// Assumes ext_bus_cfg.svh for the numeric figures.
package ext_bus_pkg;

    typedef enum logic [5:0] {
        S_IDLE = 6'h01,
        S_ADDR = 6'h02,
        S_CMD = 6'h04,
        S_DSET = 6'h08,
        S_ACC = 6'h10,
        S_HOLD = 6'h20
    } phase_e;

    typedef logic [4:0] count_t;
    typedef logic [5:0] len_t;
    typedef logic [15:0] timing_t;

endpackage

/* hw/ext_bus_sequencer.sv */
// External bus cycle sequencer with APB register access.
// Assumes an APB master on i_clk and an external memory or peripheral on the pins.
`timescale 1ns/1ps
`include "ext_bus_cfg.svh"

module ext_bus_sequencer (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic [23:0] o_addr,
    output logic o_ale,
    output logic o_rd_n,
    output logic o_wr_n,
    output logic o_upper_byte_enable_n,
    output logic [3:0] o_cs_n,
    input wire logic [15:0] i_data,
    output logic [15:0] o_data,
    output logic o_data_oe,
    input wire logic i_ready,
    output logic o_bus_reference_clock
);

    // ****************************************
    // Phase arithmetic
    // ****************************************
    function automatic ext_bus_pkg::len_t phase_len(input ext_bus_pkg::phase_e p,
        input ext_bus_pkg::timing_t t, input logic chg);
        ext_bus_pkg::len_t l;
        l = 6'h00;
        unique case (p)
            ext_bus_pkg::S_ADDR: l = 6'h01 + {5'h00, t[`TIM_AS2_BIT]}
                + (chg ? {4'h0, t[`TIM_WIN_LSB +: 2]} : 6'h00);
            ext_bus_pkg::S_CMD: l = {4'h0, t[`TIM_CMD_LSB +: 2]};
            ext_bus_pkg::S_DSET: l = {5'h00, t[`TIM_DSET_BIT]};
            ext_bus_pkg::S_ACC: l = {1'h0, t[`TIM_ACC_LSB +: 5]} + 6'h01;
            ext_bus_pkg::S_HOLD: l = {4'h0, t[`TIM_HOLD_LSB +: 2]};
            ext_bus_pkg::S_IDLE: l = 6'h00;
        endcase
        return l;
    endfunction

    // Zero-length phases are skipped, so every cycle walks the same order
    function automatic ext_bus_pkg::phase_e next_phase(input ext_bus_pkg::phase_e p,
        input ext_bus_pkg::timing_t t);
        ext_bus_pkg::phase_e n;
        n = ext_bus_pkg::S_IDLE;
        unique case (p)
            ext_bus_pkg::S_IDLE: n = ext_bus_pkg::S_ADDR;
            ext_bus_pkg::S_ADDR: n = (t[`TIM_CMD_LSB +: 2] != 2'h0) ? ext_bus_pkg::S_CMD
                : t[`TIM_DSET_BIT] ? ext_bus_pkg::S_DSET : ext_bus_pkg::S_ACC;
            ext_bus_pkg::S_CMD: n = t[`TIM_DSET_BIT] ? ext_bus_pkg::S_DSET
                : ext_bus_pkg::S_ACC;
            ext_bus_pkg::S_DSET: n = ext_bus_pkg::S_ACC;
            ext_bus_pkg::S_ACC: n = (t[`TIM_HOLD_LSB +: 2] != 2'h0) ? ext_bus_pkg::S_HOLD
                : ext_bus_pkg::S_IDLE;
            ext_bus_pkg::S_HOLD: n = ext_bus_pkg::S_IDLE;
        endcase
        return n;
    endfunction

    function automatic ext_bus_pkg::count_t len_m1(input ext_bus_pkg::len_t l);
        ext_bus_pkg::len_t d;
        d = l - 6'h01;
        return d[4:0];
    endfunction

    // ****************************************
    // Registers and pin sampling
    // ****************************************
    ext_bus_pkg::phase_e state_reg, state_next;
    ext_bus_pkg::count_t cnt_reg, cnt_next;
    ext_bus_pkg::timing_t tim_reg [0:3];
    ext_bus_pkg::timing_t cur_reg;
    logic ctrl_pol_reg;
    logic [23:0] addr_reg;
    logic [15:0] wdata_reg, rdata_reg;
    logic [1:0] cs_reg, last_cs_reg;
    logic wr_reg, ube_reg, first_reg, done_reg, waited_reg, refclk_reg, rdy_s3_reg;
    logic [15:0] data_s2;
    logic rdy_s2;

    sync_2ff #(.W(16)) u_data_sync (.i_clk(i_clk), .i_async(i_data), .o_sync(data_s2));
    sync_2ff #(.W(1)) u_rdy_sync (.i_clk(i_clk), .i_async(i_ready), .o_sync(rdy_s2));

    // Extra stage for asynchronous ready costs a wait state but removes setup limits
    always_ff @(posedge i_clk)
    begin
        rdy_s3_reg <= rdy_s2;
    end

    logic wr_acc, rd_acc, start, acc_end, rdy_active, hs_on, async_on, win_chg;
    logic [3:0] idx;
    assign wr_acc = i_psel && i_penable && i_pwrite;
    assign rd_acc = i_psel && i_penable && !i_pwrite;
    assign idx = i_paddr[5:2];
    assign start = wr_acc && (i_paddr == `OFF_CMD) && (state_reg == ext_bus_pkg::S_IDLE);
    assign win_chg = first_reg || (i_pwdata[`CMD_CS_LSB +: 2] != last_cs_reg);
    assign hs_on = cur_reg[`TIM_RDY_EN_BIT];
    assign async_on = cur_reg[`TIM_RDY_ASYNC_BIT];
    assign rdy_active = ((async_on ? rdy_s3_reg : rdy_s2) == ctrl_pol_reg);
    assign acc_end = (cnt_reg == 5'h00)
        && (!hs_on || (rdy_active && (!async_on || waited_reg)));

    // ****************************************
    // Phase sequencer
    // ****************************************
    always_comb
    begin
        state_next = state_reg;
        cnt_next = (cnt_reg != 5'h00) ? cnt_reg - 5'h01 : cnt_reg;
        unique case (state_reg)
            ext_bus_pkg::S_IDLE:
                if (start)
                begin
                    state_next = ext_bus_pkg::S_ADDR;
                    cnt_next = len_m1(phase_len(ext_bus_pkg::S_ADDR,
                        tim_reg[i_pwdata[`CMD_CS_LSB +: 2]], win_chg));
                end
            ext_bus_pkg::S_ADDR, ext_bus_pkg::S_CMD, ext_bus_pkg::S_DSET,
            ext_bus_pkg::S_HOLD:
                if (cnt_reg == 5'h00)
                begin
                    state_next = next_phase(state_reg, cur_reg);
                    cnt_next = len_m1(phase_len(state_next, cur_reg, 1'b0));
                end
            ext_bus_pkg::S_ACC:
                if (acc_end)
                begin
                    state_next = next_phase(state_reg, cur_reg);
                    cnt_next = len_m1(phase_len(state_next, cur_reg, 1'b0));
                end
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            state_reg <= ext_bus_pkg::S_IDLE;
            cnt_reg <= 5'h00;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
        end
    end

    // Async mode: the first sample point in access is never taken
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n || state_reg != ext_bus_pkg::S_ACC)
            waited_reg <= 1'b0;
        else if (cnt_reg == 5'h00)
            waited_reg <= 1'b1;
    end

    // ****************************************
    // Cycle request and capture
    // ****************************************
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            cs_reg <= 2'h0;
            last_cs_reg <= 2'h0;
            first_reg <= 1'b1;
            wr_reg <= 1'b0;
            ube_reg <= 1'b0;
            cur_reg <= `RST_TIM;
        end
        else if (start)
        begin
            cs_reg <= i_pwdata[`CMD_CS_LSB +: 2];
            last_cs_reg <= i_pwdata[`CMD_CS_LSB +: 2];
            first_reg <= 1'b0;
            wr_reg <= i_pwdata[`CMD_WRITE_BIT];
            ube_reg <= i_pwdata[`CMD_UBE_BIT];
            cur_reg <= tim_reg[i_pwdata[`CMD_CS_LSB +: 2]];
        end
    end

    // Capture on the edge that drops the strobe; address is still held then
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
            rdata_reg <= 16'h0000;
        else if (state_reg == ext_bus_pkg::S_ACC && acc_end && !wr_reg)
            rdata_reg <= data_s2;
    end

    // Set wins over a software clear in the same cycle
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
            done_reg <= 1'b0;
        else if (state_reg != ext_bus_pkg::S_IDLE && state_next == ext_bus_pkg::S_IDLE)
            done_reg <= 1'b1;
        else if (wr_acc && i_paddr == `OFF_STATUS && i_pwdata[`STAT_DONE_BIT])
            done_reg <= 1'b0;
    end

    // ****************************************
    // Software registers
    // ****************************************
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            ctrl_pol_reg <= `RST_CTRL;
            addr_reg <= 24'h000000;
            wdata_reg <= 16'h0000;
            for (int i = 0; i < 4; i++)
                tim_reg[i] <= `RST_TIM;
        end
        else if (wr_acc && state_reg == ext_bus_pkg::S_IDLE)
        begin
            // Address and data are frozen while a cycle runs
            if (i_paddr == `OFF_CTRL)
                ctrl_pol_reg <= i_pwdata[`CTRL_RDY_POL_BIT];
            if (i_paddr == `OFF_ADDR)
                addr_reg <= i_pwdata[23:0];
            if (i_paddr == `OFF_WDATA)
                wdata_reg <= i_pwdata[15:0];
            if (i_paddr >= `OFF_TIM0 && i_paddr <= `OFF_TIM3 && i_paddr[1:0] == 2'h0)
                tim_reg[idx[1:0]] <= i_pwdata[15:0];
        end
    end

    always_comb
    begin
        o_prdata = 32'h00000000;
        o_pslverr = 1'b0;
        if (i_paddr == `OFF_CTRL)
            o_prdata = {31'h00000000, ctrl_pol_reg};
        else if (i_paddr == `OFF_ADDR)
            o_prdata = {8'h00, addr_reg};
        else if (i_paddr == `OFF_WDATA)
            o_prdata = {16'h0000, wdata_reg};
        else if (i_paddr == `OFF_CMD)
            o_prdata = {28'h0000000, ube_reg, wr_reg, cs_reg};
        else if (i_paddr == `OFF_STATUS)
            o_prdata = {30'h00000000, done_reg, state_reg != ext_bus_pkg::S_IDLE};
        else if (i_paddr == `OFF_RDATA)
            o_prdata = {16'h0000, rdata_reg};
        else if (i_paddr >= `OFF_TIM0 && i_paddr <= `OFF_TIM3 && i_paddr[1:0] == 2'h0)
            o_prdata = {16'h0000, tim_reg[idx[1:0]]};
        else
            o_pslverr = i_psel && i_penable;
    end
    assign o_pready = 1'b1;

    // ****************************************
    // Bus pins
    // ****************************************
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
            refclk_reg <= 1'b0;
        else
            refclk_reg <= !refclk_reg;
    end
    assign o_bus_reference_clock = refclk_reg;

    logic in_cycle, mux_on;
    assign in_cycle = state_reg != ext_bus_pkg::S_IDLE;
    assign mux_on = cur_reg[`TIM_MUX_BIT];
    assign o_addr = addr_reg;
    assign o_ale = state_reg == ext_bus_pkg::S_ADDR;
    assign o_rd_n = !(state_reg == ext_bus_pkg::S_ACC && !wr_reg);
    assign o_wr_n = !(state_reg == ext_bus_pkg::S_ACC && wr_reg);
    assign o_upper_byte_enable_n = !(in_cycle && ube_reg);
    assign o_cs_n = in_cycle ? ~(4'h1 << cs_reg) : 4'hF;
    // Mux mode: address on data lines in the address phase, lines released in the setup turnaround
    assign o_data = (mux_on && state_reg == ext_bus_pkg::S_ADDR) ? addr_reg[15:0] : wdata_reg;
    assign o_data_oe = (mux_on && state_reg == ext_bus_pkg::S_ADDR)
        || (in_cycle && wr_reg && (state_reg == ext_bus_pkg::S_ACC
        || state_reg == ext_bus_pkg::S_HOLD
        || (state_reg == ext_bus_pkg::S_DSET && !mux_on)));

    // ****************************************
    // Checks
    // ****************************************
    logic [5:0] ph_cnt_reg;
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n || state_next != state_reg)
            ph_cnt_reg <= 6'h01;
        else if (ph_cnt_reg != 6'h3F)
            ph_cnt_reg <= ph_cnt_reg + 6'h01;
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    property p_strobe;
        (!o_rd_n || !o_wr_n) |-> state_reg == ext_bus_pkg::S_ACC;
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe outside access");

    property p_order;
        state_reg == ext_bus_pkg::S_HOLD |-> $past(state_reg) inside
            {ext_bus_pkg::S_ACC, ext_bus_pkg::S_HOLD};
    endproperty
    a_order: assert property (p_order) else $error("hold not after access");

    property p_cmd_len;
        state_reg == ext_bus_pkg::S_CMD && state_next != ext_bus_pkg::S_CMD
            |-> ph_cnt_reg == {4'h0, cur_reg[`TIM_CMD_LSB +: 2]};
    endproperty
    a_cmd_len: assert property (p_cmd_len) else $error("command phase length");

    property p_addr_len;
        state_reg == ext_bus_pkg::S_ADDR && state_next != ext_bus_pkg::S_ADDR
            |-> ph_cnt_reg >= 6'h01 + {5'h00, cur_reg[`TIM_AS2_BIT]}
            && ph_cnt_reg <= 6'h05;
    endproperty
    a_addr_len: assert property (p_addr_len) else $error("address phase length");

    property p_hold_len;
        state_reg == ext_bus_pkg::S_HOLD && state_next != ext_bus_pkg::S_HOLD
            |-> ph_cnt_reg == {4'h0, cur_reg[`TIM_HOLD_LSB +: 2]} && o_rd_n && o_wr_n;
    endproperty
    a_hold_len: assert property (p_hold_len) else $error("hold phase length");

    property p_dset;
        state_reg == ext_bus_pkg::S_DSET |=> state_reg == ext_bus_pkg::S_ACC;
    endproperty
    a_dset: assert property (p_dset) else $error("setup phase not one clock");

    property p_acc_fixed;
        state_reg == ext_bus_pkg::S_ACC && state_next != ext_bus_pkg::S_ACC && !hs_on
            |-> ph_cnt_reg == {1'h0, cur_reg[`TIM_ACC_LSB +: 5]} + 6'h01;
    endproperty
    a_acc_fixed: assert property (p_acc_fixed) else $error("access phase length");

    property p_capture;
        state_reg == ext_bus_pkg::S_ACC && !wr_reg && state_next != ext_bus_pkg::S_ACC
            |=> rdata_reg == $past(data_s2) && o_rd_n;
    endproperty
    a_capture: assert property (p_capture) else $error("read data not captured");

    property p_async_wait;
        state_reg == ext_bus_pkg::S_ACC && state_next != ext_bus_pkg::S_ACC
            && hs_on && async_on
            |-> ph_cnt_reg >= {1'h0, cur_reg[`TIM_ACC_LSB +: 5]} + 6'h02;
    endproperty
    a_async_wait: assert property (p_async_wait) else $error("no async wait state");

    property p_not_ready;
        state_reg == ext_bus_pkg::S_ACC && cnt_reg == 5'h00 && hs_on && !async_on
            && !rdy_active |=> state_reg == ext_bus_pkg::S_ACC;
    endproperty
    a_not_ready: assert property (p_not_ready) else $error("ended without ready");

    c_read: cover property (!o_rd_n ##1 o_rd_n);
    c_write: cover property (!o_wr_n ##1 state_reg == ext_bus_pkg::S_HOLD);
    c_wait: cover property (state_reg == ext_bus_pkg::S_ACC && hs_on && ph_cnt_reg == 6'h04);

endmodule // ext_bus_sequencer

/* hw/sync_2ff.sv */
// Two-stage synchroniser for pin inputs.
// Assumes inputs asynchronous to i_clk; the first stage feeds only the second.
`timescale 1ns/1ps

module sync_2ff #(
    parameter int W = 1
) (
    input wire logic i_clk,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);

    logic [W-1:0] meta_reg;

    always_ff @(posedge i_clk)
    begin
        meta_reg <= i_async;
        o_sync <= meta_reg;
    end

endmodule // sync_2ff

/* test/ext_mem_model.sv */
// External memory or peripheral model for the bus sequencer pins.
// Assumes the sequencer's pins and a testbench setting the ready handshake behaviour.
`timescale 1ns/1ps

module ext_mem_model (
    input wire logic i_clk,
    input wire logic i_refclk,
    input wire logic [3:0] i_cs_n,
    input wire logic [23:0] i_addr,
    input wire logic i_rd_n,
    input wire logic i_wr_n,
    input wire logic [15:0] i_data_out,
    input wire logic i_data_oe,
    input wire logic i_pol,
    input wire logic i_async,
    input wire logic [7:0] i_wait,
    output logic [15:0] o_data,
    output logic o_ready
);
    // ****************************************
    // Storage and read data
    // ****************************************
    logic [15:0] mem [256];
    logic [15:0] last = 16'h0000;
    logic seen_rd = 1'b0;
    logic act_s = 1'b0;
    logic act_a = 1'b0;
    logic [7:0] cnt = 8'h00;
    logic sel;
    logic want;

    initial
    begin
        for (int i = 0; i < 256; i++)
            mem[i] = 16'hC000 | 16'(i);
    end

    assign sel = (i_cs_n != 4'hF);
    // Released lines show changing garbage so a late capture cannot pass by luck
    assign o_data = (sel && !i_data_oe && !(seen_rd && i_rd_n)) ? mem[i_addr[7:0]] : ~last;

    always @(posedge i_clk)
    begin
        last <= o_data;
        seen_rd <= sel & (seen_rd | ~i_rd_n);
        if (!i_wr_n && i_data_oe)
            mem[i_addr[7:0]] <= i_data_out;
        cnt <= (i_rd_n & i_wr_n) ? 8'h00 : cnt + 8'h01;
    end

    // ****************************************
    // Ready handshake
    // ****************************************
    // Ready goes inactive once the strobe has ended
    assign want = !(i_rd_n & i_wr_n) && (cnt >= i_wait);

    always @(posedge i_clk)
    begin
        if (!i_async && !i_refclk)
            act_s <= want;
    end

    // Asynchronous ready moves on the opposite phase, unrelated to the reference clock
    always @(negedge i_clk)
    begin
        if (i_async)
            act_a <= want;
    end

    // One register per mode keeps a single driver on each
    assign o_ready = (i_async ? act_a : act_s) ? i_pol : ~i_pol;
endmodule // ext_mem_model

/* test/external_bus_cycle_phase_sequencer_tb_top.sv */
// Testbench for the external bus sequencer: APB calls run tables of bus cycles.
// Assumes ext_mem_model on the pins and ext_bus_cfg.svh on the include path.
`timescale 1ns/1ps
`include "ext_bus_cfg.svh"

module external_bus_cycle_phase_sequencer_tb_top;
    typedef struct {
        int cs, wr, ube, as2, win, cmd, dset, acc, hold, mux;
        logic [23:0] a;
        logic [15:0] d;
    } op_s;

    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pol = 1'b0, asy = 1'b0, mux_m = 1'b0;
    logic [7:0] paddr = 8'h00, wait_n = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rv;
    logic pready, pslverr, ale, rd_n, wr_n, ube_n, oe, ready, refclk, ev, ube_seen;
    logic in_cyc = 1'b0;
    logic [23:0] addr, a_stb, a_cur;
    logic [3:0] cs_n, cs_seen;
    logic [15:0] din, dout;
    logic [15:0] shadow [256];
    int err_total = 0, n_compared = 0, n_ale, n_pre, n_stb, n_post, n_cyc = 0, prev_cs = -1, c0;
    int hc [4][4] = '{'{1, 0, 6, 1}, '{0, 1, 0, 2}, '{0, 0, 6, 1}, '{1, 1, 4, 3}};
    op_s h;
    op_s tbl [5] = '{
        '{0, 1, 1, 0, 3, 0, 1, 1, 3, 0, 24'h000012, 16'hA5C3},
        '{0, 0, 0, 1, 3, 3, 0, 2, 0, 0, 24'h000012, 16'h0000},
        '{1, 1, 0, 0, 2, 1, 0, 32, 1, 1, 24'h00FF34, 16'h1E0F},
        '{2, 0, 1, 1, 1, 2, 1, 5, 2, 1, 24'h00FF34, 16'h0000},
        '{3, 0, 0, 0, 0, 0, 0, 3, 0, 0, 24'hABCD56, 16'h0000}};

    always #4 i_clk = ~i_clk;

    ext_bus_sequencer dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_addr(addr),
        .o_ale(ale), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_upper_byte_enable_n(ube_n),
        .o_cs_n(cs_n), .i_data(din), .o_data(dout), .o_data_oe(oe), .i_ready(ready),
        .o_bus_reference_clock(refclk));

    ext_mem_model mem (.i_clk(i_clk), .i_refclk(refclk), .i_cs_n(cs_n), .i_addr(addr),
        .i_rd_n(rd_n), .i_wr_n(wr_n), .i_data_out(dout), .i_data_oe(oe), .i_pol(pol),
        .i_async(asy), .i_wait(wait_n), .o_data(din), .o_ready(ready));

    // ****************************************
    // Checking and bus tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wrap_up;
        if (err_total == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // One APB transfer, then one idle clock so psel is never driven twice in a step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int k = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge i_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge i_clk);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1)
        begin
            err_total++;
            wrap_up();
        end
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge i_clk);
    endtask

    task automatic wait_idle;
        int k = 0;
        do
        begin
            apb(1'b0, `OFF_STATUS, 32'h0);
            k++;
        end
        while (rv[`STAT_BUSY_BIT] !== 1'b0 && k < 100);
        if (rv[`STAT_BUSY_BIT] !== 1'b0)
        begin
            err_total++;
            wrap_up();
        end
    endtask

    function automatic logic [15:0] tim(input op_s o, input int rdy, input int asm);
        return 16'((o.as2 << `TIM_AS2_BIT) | (o.win << `TIM_WIN_LSB) | (o.cmd << `TIM_CMD_LSB)
            | (o.dset << `TIM_DSET_BIT) | ((o.acc - 1) << `TIM_ACC_LSB)
            | (o.hold << `TIM_HOLD_LSB) | (rdy << `TIM_RDY_EN_BIT)
            | (asm << `TIM_RDY_ASYNC_BIT) | (o.mux << `TIM_MUX_BIT));
    endfunction

    task automatic start(input op_s o, input logic [15:0] tv);
        apb(1'b1, 8'(`OFF_TIM0 + 4 * o.cs), {16'h0000, tv});
        apb(1'b1, `OFF_ADDR, {8'h00, o.a});
        apb(1'b1, `OFF_WDATA, {16'h0000, o.d});
        mux_m = o.mux[0];
        a_cur = o.a;
        n_ale = 0;
        n_pre = 0;
        n_stb = 0;
        n_post = 0;
        c0 = n_cyc;
        apb(1'b1, `OFF_CMD, 32'(o.cs | (o.wr << `CMD_WRITE_BIT) | (o.ube << `CMD_UBE_BIT)));
    endtask

    task automatic check_op(input op_s o, input int lo, input int hi);
        chk(n_ale, 1 + o.as2 + ((o.cs != prev_cs) ? o.win : 0));
        chk(n_pre, o.cmd + o.dset);
        chk(n_stb >= lo && n_stb <= hi, 1);
        chk(n_post, o.hold);
        chk({cs_seen, ube_seen, a_stb}, {~(4'h1 << o.cs), ~o.ube[0], o.a});
        chk(rv, 32'h0000_0002);
        if (o.wr)
            shadow[o.a[7:0]] = o.d;
        else
        begin
            apb(1'b0, `OFF_RDATA, 32'h0);
            chk(rv, {16'h0000, shadow[o.a[7:0]]});
        end
        apb(1'b1, `OFF_STATUS, 32'h0000_0002);
        prev_cs = o.cs;
    endtask

    // ****************************************
    // Pin monitor and main sequence
    // ****************************************
    always @(posedge i_clk)
    begin
        if (i_rst_n && cs_n !== 4'hF)
        begin
            if (!in_cyc)
                n_cyc++;
            in_cyc = 1'b1;
            cs_seen = cs_n;
            if (ale === 1'b1)
                n_ale++;
            else if ((rd_n & wr_n) === 1'b0)
            begin
                n_stb++;
                a_stb = addr;
                ube_seen = ube_n;
            end
            else if (n_stb == 0)
                n_pre++;
            else
                n_post++;
            if (mux_m && ale === 1'b1)
                chk({oe, dout}, {1'b1, a_cur[15:0]});
        end
        else
            in_cyc = 1'b0;
    end

    initial
    begin
        for (int i = 0; i < 256; i++)
            shadow[i] = 16'hC000 | 16'(i);
        repeat (8) @(posedge i_clk);
        chk({cs_n, rd_n, wr_n, ale, oe, refclk}, {4'hF, 5'h18});
        i_rst_n <= 1'b1;
        @(posedge i_clk);
        for (int i = 0; i < 6; i++)
        begin
            apb(1'b0, (i < 4) ? 8'(`OFF_TIM0 + 4 * i) : ((i == 4) ? `OFF_CTRL : 8'h18), 32'h0);
            chk(32'(ev), 32'(i == 5));
            chk(rv, 32'h0);
        end
        foreach (tbl[i])
        begin
            start(tbl[i], tim(tbl[i], 0, 0));
            wait_idle();
            check_op(tbl[i], tbl[i].acc, tbl[i].acc);
        end
        // Commands and address writes while busy are dropped
        start(tbl[2], tim(tbl[2], 0, 0));
        apb(1'b1, `OFF_ADDR, 32'h0000_0777);
        apb(1'b1, `OFF_CMD, 32'h0000_0003);
        wait_idle();
        check_op(tbl[2], 32, 32);
        chk(n_cyc - c0, 1);
        apb(1'b0, `OFF_ADDR, 32'h0);
        chk(rv, {8'h00, tbl[2].a});
        apb(1'b0, `OFF_STATUS, 32'h0);
        chk(rv, 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            h = '{0, 0, 0, 0, 0, 0, 0, hc[i][3], 0, 0, 24'h000040, 16'h0000};
            pol <= hc[i][0][0];
            asy <= hc[i][1][0];
            wait_n <= 8'(hc[i][2]);
            apb(1'b1, `OFF_CTRL, 32'(hc[i][0]));
            start(h, tim(h, 1, hc[i][1]));
            wait_idle();
            check_op(h, (h.acc + hc[i][1] > hc[i][2] + 1) ? h.acc + hc[i][1] : hc[i][2] + 1,
                hc[i][2] + h.acc + 6);
        end
        wrap_up();
    end
endmodule // external_bus_cycle_phase_sequencer_tb_top
